/* sysctl_pkg.sv */
// package: timing counts, vectors and states for the bus system control block
package sysctl_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned RESET_INIT_NS   = 8_000;   // least init pulse for reset instruction
  localparam int unsigned RESET_INIT_CYC  = (RESET_INIT_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam int unsigned DOWN_INIT_NS    = 1_000;   // least delay after dc good drops
  localparam int unsigned DOWN_INIT_CYC   = (DOWN_INIT_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam int unsigned RESUME_INIT_CYC = RESET_INIT_CYC;
  localparam logic [8:0]  EVENT_VECTOR    = 9'h040;  // octal 100
  localparam logic [8:0]  POWER_FAIL_VECTOR = 9'h018; // octal 30
  localparam int unsigned CNT_W           = 16;

  typedef enum logic [2:0] {
    ST_POWER_UP   = 3'b000,
    ST_RUN        = 3'b001,
    ST_PWR_FAIL   = 3'b010,
    ST_DOWN_WAIT  = 3'b011,
    ST_POWER_DOWN = 3'b100
  } seq_state_type;
endpackage

/* sync_if.sv */
// interface: synchronised power, halt and event levels
`timescale 1ns/1ns
`default_nettype none
interface sync_if;
  logic dc_good;
  logic ac_good;
  logic halt;
  logic event_req;
  modport src (output dc_good, ac_good, halt, event_req);
  modport dst (input dc_good, ac_good, halt, event_req);
endinterface
`default_nettype wire

/* status_sync.sv */
// two-stage synchronisers for the asynchronous bus status inputs
`timescale 1ns/1ns
`default_nettype none
module status_sync #(
  parameter int unsigned N = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] async_in,
  sync_if.src               sync
);
  logic [N-1:0] meta_r;
  logic [N-1:0] stable_r;

  // meta_r feeds stable_r only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= '0;
      stable_r <= '0;
    end else begin
      meta_r   <= async_in;  // see RULE_17
      stable_r <= meta_r;
    end
  end

  assign sync.dc_good   = stable_r[0];
  assign sync.ac_good   = stable_r[1];
  assign sync.halt      = stable_r[2];
  assign sync.event_req = stable_r[3];
endmodule
`default_nettype wire

/* bus_system_control.sv */
// bus system control: power sequencing, bus initialize, halt and line clock event
//
// Contract
// (RULE_01) refresh strobe is others' job; never driven
// (RULE_02) halt line forces console debug mode
// (RULE_03) programmed halt never drives halt line
// (RULE_04) initialize on power-down, power-up, reset, resume
// (RULE_05) supply asserts dc good after 3 ms
// (RULE_06) ac good after 70 ms dc good
// (RULE_07) ac good drop while running traps
// (RULE_08) release power-up initialize after dc good
// (RULE_09) supply drops dc good if unstable
// (RULE_10) dc good held 4 ms after ac drop
// (RULE_11) power-down runs to completion once started
// (RULE_12) pending master requests hold until initialize
// (RULE_13) reset instruction drives initialize 8 to 20 us
// (RULE_14) initialize at least 1 us after dc drop
// (RULE_15) dc good stays low at least 3 ms
// (RULE_16) event interrupt uses fixed vector octal 100
// (RULE_17) async status inputs pass two-stage synchroniser
`timescale 1ns/1ns
`default_nettype none
module bus_system_control #(
  parameter int unsigned RESET_CYC  = sysctl_pkg::RESET_INIT_CYC,
  parameter int unsigned DOWN_CYC   = sysctl_pkg::DOWN_INIT_CYC,
  parameter int unsigned RESUME_CYC = sysctl_pkg::RESUME_INIT_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       dc_power_good,
  input  wire logic       ac_power_good,
  input  wire logic       halt_request_line_n,
  input  wire logic       line_clock_event_n,
  input  wire logic       reset_instr,
  input  wire logic       console_resume,
  input  wire logic       halt_instr,
  input  wire logic       event_ack,
  input  wire logic       power_fail_ack,
  output logic            bus_initialize_n_out,
  output logic            bus_initialize_n_oe_n,
  output logic            halt_request_line_n_out,
  output logic            halt_request_line_n_oe_n,
  output logic            refresh_strobe_n_out,
  output logic            refresh_strobe_n_oe_n,
  output logic            console_debug_mode,
  output logic            cpu_run,
  output logic            power_fail_trap,
  output logic            event_irq,
  output logic [8:0]      irq_vector,
  output logic            vector_read_skip,
  output logic            resume_go
);
  sync_if sync ();

  status_sync #(
    .N (4)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({~line_clock_event_n, ~halt_request_line_n, ac_power_good, dc_power_good}),
    .sync     (sync)
  );

  sysctl_pkg::seq_state_type state_r;
  sysctl_pkg::seq_state_type state_nxt;
  logic [sysctl_pkg::CNT_W-1:0] down_cnt_r;
  logic [sysctl_pkg::CNT_W-1:0] pulse_cnt_r;
  logic                         pulse_busy;
  logic                         ac_prev_r;
  logic                         dc_prev_r;
  logic                         debug_r;
  logic                         resume_pend_r;
  logic                         init_active;
  logic                         ac_fall;

  assign pulse_busy = (pulse_cnt_r != '0);
  assign ac_fall    = ac_prev_r & ~sync.ac_good;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ac_prev_r <= 1'b0;
      dc_prev_r <= 1'b0;
    end else begin
      ac_prev_r <= sync.ac_good;
      dc_prev_r <= sync.dc_good;
    end
  end

  // power sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sysctl_pkg::ST_POWER_UP: begin
        if (sync.dc_good) begin
          state_nxt = sysctl_pkg::ST_RUN;  // see RULE_08
        end
      end
      sysctl_pkg::ST_RUN: begin
        if (ac_fall) begin
          state_nxt = sysctl_pkg::ST_PWR_FAIL;  // see RULE_07
        end else if (!sync.dc_good) begin
          state_nxt = sysctl_pkg::ST_DOWN_WAIT;
        end
      end
      sysctl_pkg::ST_PWR_FAIL: begin
        // no way back to run: the whole power-down completes, see RULE_11
        if (!sync.dc_good) begin
          state_nxt = sysctl_pkg::ST_DOWN_WAIT;
        end
      end
      sysctl_pkg::ST_DOWN_WAIT: begin
        if (down_cnt_r >= DOWN_CYC[sysctl_pkg::CNT_W-1:0]) begin
          state_nxt = sysctl_pkg::ST_POWER_DOWN;  // see RULE_14
        end
      end
      sysctl_pkg::ST_POWER_DOWN: begin
        // dc good held low by supply for 3 ms; restart on return
        if (sync.dc_good && !dc_prev_r) begin
          state_nxt = sysctl_pkg::ST_POWER_UP;
        end
      end
      default: state_nxt = sysctl_pkg::ST_POWER_UP;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sysctl_pkg::ST_POWER_UP;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      down_cnt_r <= '0;
    end else if (state_r != sysctl_pkg::ST_DOWN_WAIT) begin
      down_cnt_r <= '0;
    end else if (down_cnt_r != '1) begin
      down_cnt_r <= down_cnt_r + 1'b1;
    end
  end

  // timed initialize pulse for reset instruction and console resume
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_r <= '0;
    end else if (pulse_busy) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end else if (reset_instr && cpu_run) begin
      pulse_cnt_r <= RESET_CYC[sysctl_pkg::CNT_W-1:0];  // see RULE_13
    end else if (console_resume && debug_r && !sync.halt) begin
      pulse_cnt_r <= RESUME_CYC[sysctl_pkg::CNT_W-1:0];  // see RULE_04
    end
  end

  // resume waits until its initialize pulse has ended
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resume_pend_r <= 1'b0;
      resume_go     <= 1'b0;
    end else begin
      resume_go <= 1'b0;
      if (!pulse_busy && console_resume && debug_r && !sync.halt && !resume_pend_r) begin
        resume_pend_r <= 1'b1;
      end else if (resume_pend_r && pulse_cnt_r == {{(sysctl_pkg::CNT_W-1){1'b0}}, 1'b1}) begin
        resume_pend_r <= 1'b0;
        resume_go     <= 1'b1;  // see RULE_04
      end
    end
  end

  // console debug mode and programmed halt
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      debug_r <= 1'b0;
    end else if (sync.halt) begin
      debug_r <= 1'b1;  // see RULE_02
    end else if (halt_instr && cpu_run) begin
      debug_r <= 1'b1;  // halt line stays released, see RULE_03
    end else if (resume_go) begin
      debug_r <= 1'b0;
    end
  end

  // power-fail trap request, held until taken or power-down
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_fail_trap <= 1'b0;
    end else if (state_r == sysctl_pkg::ST_RUN && ac_fall && !debug_r) begin
      power_fail_trap <= 1'b1;  // see RULE_07
    end else if (power_fail_ack || state_r == sysctl_pkg::ST_POWER_DOWN) begin
      power_fail_trap <= 1'b0;
    end
  end

  // line clock event: level request, internal vector, no vector read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      event_irq        <= 1'b0;
      vector_read_skip <= 1'b0;
      irq_vector       <= '0;
    end else begin
      event_irq        <= sync.event_req & cpu_run & ~event_ack;
      vector_read_skip <= sync.event_req | power_fail_trap;  // see RULE_16
      if (power_fail_trap) begin
        irq_vector <= sysctl_pkg::POWER_FAIL_VECTOR;
      end else if (sync.event_req) begin
        irq_vector <= sysctl_pkg::EVENT_VECTOR;  // see RULE_16
      end
    end
  end

  assign init_active = (state_r == sysctl_pkg::ST_POWER_UP) ||
                       (state_r == sysctl_pkg::ST_POWER_DOWN) || pulse_busy;

  // open-drain bus lines: enable low means pulling the line low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_initialize_n_oe_n <= 1'b0;  // initialize asserted through reset
    end else begin
      bus_initialize_n_oe_n <= ~init_active;  // see RULE_04
    end
  end

  assign bus_initialize_n_out     = 1'b0;
  assign halt_request_line_n_out  = 1'b0;
  assign halt_request_line_n_oe_n = 1'b1;  // see RULE_03
  // refresh is left to memory or dma masters, see RULE_01
  assign refresh_strobe_n_out     = 1'b0;
  assign refresh_strobe_n_oe_n    = 1'b1;
  assign console_debug_mode       = debug_r;
  assign cpu_run = (state_r == sysctl_pkg::ST_RUN || state_r == sysctl_pkg::ST_PWR_FAIL) &&
                   !debug_r && !pulse_busy;
endmodule
`default_nettype wire

/* bus_system_control_props.sv */
// checker: port-level properties of the bus system control block
`timescale 1ns/1ns
`default_nettype none
module bus_system_control_props (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       dc_power_good,
  input wire logic       ac_power_good,
  input wire logic       halt_request_line_n,
  input wire logic       reset_instr,
  input wire logic       console_resume,
  input wire logic       bus_initialize_n_oe_n,
  input wire logic       halt_request_line_n_oe_n,
  input wire logic       console_debug_mode,
  input wire logic       cpu_run,
  input wire logic       power_fail_trap,
  input wire logic       event_irq,
  input wire logic [8:0] irq_vector,
  input wire logic       vector_read_skip
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_halt_undriven:
    assert property (halt_request_line_n_oe_n) else $error("halt line driven");
  a_halt_debug:
    assert property (!halt_request_line_n [*5] |-> console_debug_mode && !cpu_run)
    else $error("halt line ignored");
  a_reset_init:
    assert property (reset_instr && cpu_run |-> ##[2:3] !bus_initialize_n_oe_n)
    else $error("reset gave no initialize");
  a_resume_init:
    assert property (console_resume && console_debug_mode && halt_request_line_n
      && $past(halt_request_line_n, 2)
      |-> ##[2:3] !bus_initialize_n_oe_n) else $error("resume gave no initialize");
  a_reset_width:
    assert property ($fell(bus_initialize_n_oe_n) && $past(reset_instr, 2)
      && $past(cpu_run, 2)
      |-> !bus_initialize_n_oe_n [*4]) else $error("initialize pulse short");
  a_dc_drop_init:
    assert property ($fell(dc_power_good) && bus_initialize_n_oe_n
      |-> bus_initialize_n_oe_n [*3] ##[1:8] !bus_initialize_n_oe_n)
    else $error("power-down initialize mistimed");
  a_release_dc:
    assert property ($rose(bus_initialize_n_oe_n) |-> $past(dc_power_good, 2))
    else $error("initialize released before dc good");
  a_ac_trap:
    assert property ($fell(ac_power_good) && cpu_run |-> ##[1:4] power_fail_trap)
    else $error("no power-fail trap");
  a_event_vector:
    assert property (event_irq && !power_fail_trap
      |-> irq_vector == sysctl_pkg::EVENT_VECTOR && vector_read_skip)
    else $error("event vector wrong");
endmodule
bind bus_system_control bus_system_control_props props (.*);
`default_nettype wire

/* psu_model.sv */
// partner: power supply model driving the dc and ac good levels
`timescale 1ns/1ns
`default_nettype none
module psu_model #(
  parameter int unsigned AC_DELAY = 14,
  parameter int unsigned DC_HOLD  = 8,
  parameter int unsigned OFF_MIN  = 6
) (
  input  wire logic clk_sys,
  output var logic  dc_power_good,
  output var logic  ac_power_good
);
  // waits are scaled to cycles: real milliseconds would run far too long
  initial begin
    dc_power_good = 1'b0;
    ac_power_good = 1'b0;
  end
  task automatic power_up();
    repeat (OFF_MIN) @(posedge clk_sys);
    dc_power_good <= 1'b1;
    repeat (AC_DELAY) @(posedge clk_sys);
    ac_power_good <= 1'b1;
  endtask
  task automatic ac_drop();
    @(posedge clk_sys) ac_power_good <= 1'b0;
    repeat (DC_HOLD) @(posedge clk_sys);
  endtask
  task automatic dc_drop();
    @(posedge clk_sys) dc_power_good <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb_bus_system_control.sv */
// testbench: directed scenarios for the bus system control block
`timescale 1ns/1ns
`default_nettype none
module tb_bus_system_control;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       halt_n = 1'b1;
  logic       event_n = 1'b1;
  logic       reset_instr = 1'b0;
  logic       resume = 1'b0;
  logic       halt_instr = 1'b0;
  logic       event_ack = 1'b0;
  logic       pf_ack = 1'b0;
  logic       dc_good, ac_good, init_oe_n, halt_oe_n, debug, run, trap, irq, skip;
  logic       init_out, halt_out, ref_out, ref_oe_n, go;
  logic       req_start = 1'b0;
  logic       master_req = 1'b0;
  int         go_count = 0;
  logic [8:0] vec;
  int         err_count = 0;
  int         checks = 0;

  always #25 clk_sys = ~clk_sys;

  psu_model psu (.clk_sys, .dc_power_good(dc_good), .ac_power_good(ac_good));

  bus_system_control #(.RESET_CYC(4), .DOWN_CYC(2), .RESUME_CYC(4)) dut (
    .clk_sys, .rst_n, .dc_power_good(dc_good), .ac_power_good(ac_good),
    .halt_request_line_n(halt_n), .line_clock_event_n(event_n), .reset_instr,
    .console_resume(resume), .halt_instr, .event_ack, .power_fail_ack(pf_ack),
    .bus_initialize_n_out(init_out), .bus_initialize_n_oe_n(init_oe_n),
    .halt_request_line_n_out(halt_out), .halt_request_line_n_oe_n(halt_oe_n),
    .refresh_strobe_n_out(ref_out), .refresh_strobe_n_oe_n(ref_oe_n),
    .console_debug_mode(debug),
    .cpu_run(run), .power_fail_trap(trap), .event_irq(irq), .irq_vector(vec),
    .vector_read_skip(skip), .resume_go(go));

  // resume_go stands one cycle; count its pulses at each rising edge
  always @(posedge clk_sys) begin
    if (go === 1'b1) begin
      go_count <= go_count + 1;
    end
  end

  // bus requester model: a pending mastership request stays up until initialize
  always @(posedge clk_sys) begin
    if (init_oe_n === 1'b0) begin
      master_req <= 1'b0;
    end else if (req_start) begin
      master_req <= 1'b1;
    end
  end

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // bounded wait for initialize, then its length in cycles
  task automatic measure_init(output int lo);
    int w = 0;
    lo = 0;
    while (init_oe_n !== 1'b0 && w < 12) begin
      @(negedge clk_sys);
      w++;
    end
    while (init_oe_n === 1'b0 && lo < 40) begin
      @(negedge clk_sys);
      lo++;
    end
  endtask

  task automatic t_power_up();
    @(negedge clk_sys);
    check("init before dc good", init_oe_n, 1'b0);
    psu.power_up();
    @(negedge clk_sys);
    check("init released", init_oe_n, 1'b1);
    check("running", run, 1'b1);
    check("init data low", init_out, 1'b0);
    check("refresh undriven", ref_oe_n, 1'b1);
    check("refresh data", ref_out, 1'b0);
    $display("power up test done");
  endtask

  // one console resume: initialize cycles, resume pulses, debug level after
  task automatic resume_once(input string what, input logic [8:0] exp_lo, input int exp_go);
    int lo;
    int go0;
    go0 = go_count;
    @(posedge clk_sys) resume <= 1'b1;
    @(posedge clk_sys) resume <= 1'b0;
    measure_init(lo);
    check(what, 9'(lo), exp_lo);
    check("resume go pulses", 9'(go_count - go0), 9'(exp_go));
    repeat (2) @(negedge clk_sys);
    check("debug after resume", debug, (exp_go == 0) ? 9'h001 : 9'h000);
  endtask

  task automatic t_reset();
    int lo;
    @(posedge clk_sys) reset_instr <= 1'b1;
    @(posedge clk_sys) reset_instr <= 1'b0;
    measure_init(lo);
    check("reset init cycles", 9'(lo), 9'h004);
    $display("reset test done");
  endtask

  task automatic t_halt();
    // programmed halt first: debug without touching the halt line
    @(posedge clk_sys) halt_instr <= 1'b1;
    @(posedge clk_sys) halt_instr <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check("programmed halt debug", debug, 1'b1);
    check("halt line oe_n", halt_oe_n, 1'b1);
    check("halt line data", halt_out, 1'b0);
    resume_once("halt resume init", 9'h004, 1);
    // debug is clear again, so only the halt line can set it now
    @(posedge clk_sys) halt_n <= 1'b0;
    repeat (6) @(negedge clk_sys);
    check("debug mode", debug, 1'b1);
    check("run stopped", run, 1'b0);
    // resume while the halt line is still held must be refused
    resume_once("held resume init", 9'h000, 0);
    @(posedge clk_sys) halt_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    resume_once("resume init cycles", 9'h004, 1);
    $display("halt test done");
  endtask

  task automatic t_event();
    @(posedge clk_sys) event_n <= 1'b0;
    @(negedge clk_sys);
    check("event not yet synced", irq, 1'b0);
    repeat (5) @(negedge clk_sys);
    check("event irq", irq, 1'b1);
    check("event vector", vec, sysctl_pkg::EVENT_VECTOR);
    check("vector read skipped", skip, 1'b1);
    @(posedge clk_sys) event_ack <= 1'b1;
    event_n <= 1'b1;
    repeat (2) @(negedge clk_sys);
    check("event masked", irq, 1'b0);
    @(posedge clk_sys) event_ack <= 1'b0;
    $display("event test done");
  endtask

  task automatic t_power_down();
    @(posedge clk_sys) req_start <= 1'b1;
    @(posedge clk_sys) req_start <= 1'b0;
    psu.ac_drop();
    @(negedge clk_sys);
    check("power-fail trap", trap, 1'b1);
    check("trap vector", vec, sysctl_pkg::POWER_FAIL_VECTOR);
    @(posedge clk_sys) pf_ack <= 1'b1;
    @(posedge clk_sys) pf_ack <= 1'b0;
    @(negedge clk_sys);
    check("trap taken", trap, 1'b0);
    check("master request held", master_req, 1'b1);
    psu.dc_drop();
    repeat (3) @(negedge clk_sys);
    check("init held off", init_oe_n, 1'b1);
    repeat (6) @(negedge clk_sys);
    check("init in power-down", init_oe_n, 1'b0);
    check("master request dropped", master_req, 1'b0);
    $display("power down test done");
  endtask

  // tests need some 150 cycles; 2000 is ample
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_power_up();
    t_reset();
    t_halt();
    t_event();
    t_power_down();
    t_power_up();
    tally_and_finish();
  end
endmodule
`default_nettype wire
